/* File: core/amss_core.sv */
// Start-up sequencer: config load, strap address decode, mode select,
// conversion gating, pre-bias low-side ramp and reference soft-start.
// Assumes a config store handshake, a strap ADC and a PWM core on clock_i;
// comparator outputs arrive asynchronously.
`timescale 1ns/1ps
module amss_core
    import amss_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
)(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Avalon-MM slave
    input wire amss_avreq_t avs_i,
    output amss_avrsp_t avs_o,
    // Config store
    output logic cfg_req_o,
    input wire logic cfg_ack_i,
    input wire amss_cfg_t cfg_data_i,
    // Strap and input voltage converter
    output logic adc_start_o,
    input wire logic adc_done_i,
    input wire logic [9:0] adc_code_i,
    input wire logic [9:0] vin_code_i,
    // Comparators, asynchronous
    input wire amss_cmp_t cmp_i,
    // PWM core
    input wire logic pwm_cycle_i,
    input wire logic hs_gate_i,
    // Bus address outputs
    output logic [6:0] two_wire_addr_o,
    output logic two_wire_en_o,
    output logic [6:0] power_bus_addr_o,
    output logic power_bus_en_o,
    output logic analog_mode_o,
    // Power stage control
    output logic [7:0] vin_on_level_o,
    output logic [7:0] vin_off_level_o,
    output logic convert_en_o,
    output logic ls_en_o,
    output logic [3:0] ls_duty_o,
    output logic [9:0] ref_code_o,
    output logic ramp_done_o,
    output logic guard_arm_o,
    output logic fault_o
);

    // ----------------------------------------
    // Comparator synchronisers
    // ----------------------------------------
    amss_cmp_t s1_q, s2_q, s3_q, cmp_q, cmp_d;

    always_comb
    begin
        // Take a new level only once the two late stages agree
        cmp_d = (s2_q & s3_q) | (cmp_q & (s2_q | s3_q));
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            cmp_q <= '0;
        end
        else
        begin
            s1_q <= cmp_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            cmp_q <= cmp_d;
        end
    end

    // ----------------------------------------
    // Initialization and strap decode
    // ----------------------------------------
    amss_init_t init_q, init_d;
    logic cfg_req_q, cfg_req_d, adc_start_q, adc_start_d;
    logic analog_q, analog_d;
    logic [3:0] offset_q, offset_d;
    logic [14:0] above;
    logic [3:0] bin;

    genvar gi;
    generate
        for (gi = 0; gi < 15; gi++)
        begin : g_bin
            assign above[gi] = adc_code_i >= STRAP_BOUND[gi];
        end
    endgenerate

    always_comb
    begin
        bin = 4'h0;
        for (int k = 0; k < 15; k++)
        begin
            bin = bin + {3'h0, above[k]};
        end
    end

    always_comb
    begin
        init_d = init_q;
        cfg_req_d = 1'b0;
        adc_start_d = 1'b0;
        analog_d = analog_q;
        offset_d = offset_q;
        case (init_q)
            INIT_LOAD:
            begin
                cfg_req_d = !cfg_ack_i;
                if (cfg_ack_i)
                begin
                    init_d = INIT_STRAP;
                    adc_start_d = 1'b1;
                end
            end
            INIT_STRAP:
            begin
                if (adc_done_i)
                begin
                    init_d = INIT_READY;
                    analog_d = adc_code_i >= STRAP_FLOAT;
                    offset_d = bin;
                end
            end
            INIT_READY: ;
            default: init_d = INIT_LOAD;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            init_q <= INIT_LOAD;
            cfg_req_q <= 1'b0;
            adc_start_q <= 1'b0;
            analog_q <= 1'b0;
            offset_q <= 4'h0;
        end
        else
        begin
            init_q <= init_d;
            cfg_req_q <= cfg_req_d;
            adc_start_q <= adc_start_d;
            analog_q <= analog_d;
            offset_q <= offset_d;
        end
    end

    // ----------------------------------------
    // Working registers and Avalon slave
    // ----------------------------------------
    amss_cfg_t cfg_q, cfg_d;
    amss_avrsp_t rsp_q, rsp_d;
    logic ready, take, wr_ok;
    logic tw_en_q, tw_en_d, pb_en_q, pb_en_d;
    logic [6:0] tw_addr_q, tw_addr_d, pb_addr_q, pb_addr_d;
    logic [31:0] status;
    logic conv_q, ramp_done_q, fault_q;

    assign ready = init_q == INIT_READY;
    assign take = (avs_i.read || avs_i.write) && !rsp_q.waitrequest;
    // Analog mode locks the working set; loading must finish first
    assign wr_ok = avs_i.write && take && ready && !analog_q && avs_i.byteenable[0];

    always_comb
    begin
        status = '0;
        status[ST_LOADED] = ready;
        status[ST_ANALOG] = analog_q;
        status[ST_CONVERT] = conv_q;
        status[ST_RAMP_DONE] = ramp_done_q;
        status[ST_FAULT] = fault_q;
        status[ST_VIN_OV] = cmp_q.vin_ov;
        status[ST_VIN_UVW] = cmp_q.vin_uvw;
        status[ST_OFFSET_LSB +: 4] = offset_q;
    end

    always_comb
    begin
        cfg_d = cfg_q;
        rsp_d = rsp_q;
        if (init_q == INIT_LOAD && cfg_ack_i)
        begin
            cfg_d = cfg_data_i;
        end
        if (wr_ok)
        begin
            case (avs_i.address)
                OFS_TWO_WIRE_BASE: cfg_d.two_wire_base = avs_i.writedata[6:0];
                OFS_POWER_BUS_BASE: cfg_d.power_bus_base = avs_i.writedata[6:0];
                OFS_TON_DELAY: cfg_d.ton_delay = avs_i.writedata[6:0];
                OFS_TON_RISE: cfg_d.ton_rise = avs_i.writedata[6:0];
                OFS_VIN_ON: cfg_d.vin_on = avs_i.writedata[7:0];
                OFS_VIN_OFF: cfg_d.vin_off = avs_i.writedata[7:0];
                default: ;
            endcase
        end
        // One wait state: data is set up while waitrequest still high
        rsp_d.waitrequest = !((avs_i.read || avs_i.write) && rsp_q.waitrequest);
        if (avs_i.read && rsp_q.waitrequest)
        begin
            case (avs_i.address)
                OFS_TWO_WIRE_BASE: rsp_d.readdata = {25'h0, cfg_q.two_wire_base};
                OFS_POWER_BUS_BASE: rsp_d.readdata = {25'h0, cfg_q.power_bus_base};
                OFS_TON_DELAY: rsp_d.readdata = {25'h0, cfg_q.ton_delay};
                OFS_TON_RISE: rsp_d.readdata = {25'h0, cfg_q.ton_rise};
                OFS_VIN_ON: rsp_d.readdata = {24'h0, cfg_q.vin_on};
                OFS_VIN_OFF: rsp_d.readdata = {24'h0, cfg_q.vin_off};
                OFS_STATUS: rsp_d.readdata = status;
                OFS_VIN_READ: rsp_d.readdata = {22'h0, vin_code_i};
                OFS_REF_READ: rsp_d.readdata = {22'h0, ref_code_o};
                default: rsp_d.readdata = 32'h0000_0000;
            endcase
        end
        tw_addr_d = cfg_q.two_wire_base + {3'h0, offset_q};
        pb_addr_d = cfg_q.power_bus_base + {3'h0, offset_q};
        tw_en_d = ready && !analog_q && (cfg_q.two_wire_base != 7'h00);
        pb_en_d = ready && !analog_q && (cfg_q.power_bus_base != 7'h00);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            cfg_q <= RST_CFG;
            rsp_q <= '{32'h0000_0000, 1'b1};
            tw_addr_q <= RST_TWO_WIRE_BASE;
            pb_addr_q <= RST_POWER_BUS_BASE;
            tw_en_q <= 1'b0;
            pb_en_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            rsp_q <= rsp_d;
            tw_addr_q <= tw_addr_d;
            pb_addr_q <= pb_addr_d;
            tw_en_q <= tw_en_d;
            pb_en_q <= pb_en_d;
        end
    end

    // ----------------------------------------
    // Conversion gate and guards
    // ----------------------------------------
    logic conv_d, fault_d, guard_q;

    always_comb
    begin
        // A trip in the same cycle as enable drop still latches
        fault_d = cmp_q.oc_trip || cmp_q.ov_trip || (fault_q && cmp_q.turn_on);
        conv_d = ready && cmp_q.turn_on && cmp_q.uv_lock_ok && !fault_q;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            conv_q <= 1'b0;
            fault_q <= 1'b0;
            guard_q <= 1'b0;
        end
        else
        begin
            conv_q <= conv_d;
            fault_q <= fault_d;
            guard_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Pre-bias low-side ramp
    // ----------------------------------------
    logic hs_seen_q, hs_seen_d, ls_en_q, ls_en_d;
    logic [3:0] duty_q, duty_d;
    logic [4:0] pcnt_q, pcnt_d;

    always_comb
    begin
        hs_seen_d = hs_seen_q || (conv_q && hs_gate_i);
        ls_en_d = ls_en_q;
        duty_d = duty_q;
        pcnt_d = pcnt_q;
        if (!conv_q)
        begin
            hs_seen_d = 1'b0;
            ls_en_d = 1'b0;
            duty_d = 4'h0;
            pcnt_d = 5'h00;
        end
        else if (hs_seen_q && !ls_en_q)
        begin
            ls_en_d = 1'b1;
            duty_d = 4'h1;
            pcnt_d = 5'h00;
        end
        else if (ls_en_q && pwm_cycle_i && duty_q != LS_FULL_STEPS)
        begin
            pcnt_d = pcnt_q + 5'h01;
            if (pcnt_q == LS_STEP_CYCLES - 5'h01)
            begin
                pcnt_d = 5'h00;
                duty_d = duty_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            hs_seen_q <= 1'b0;
            ls_en_q <= 1'b0;
            duty_q <= 4'h0;
            pcnt_q <= 5'h00;
        end
        else
        begin
            hs_seen_q <= hs_seen_d;
            ls_en_q <= ls_en_d;
            duty_q <= duty_d;
            pcnt_q <= pcnt_d;
        end
    end

    // ----------------------------------------
    // Reference soft-start
    // ----------------------------------------
    amss_seq_t seq_q, seq_d;
    logic [14:0] ms_q, ms_d;
    logic [6:0] dly_q, dly_d, rise;
    logic [21:0] acc_q, acc_d, span;
    logic [9:0] ref_q, ref_d;
    logic tick;

    // Analog mode runs the stored defaults; zero rise clamps to 1 ms
    assign rise = (cfg_q.ton_rise == 7'h00) ? 7'h01 : cfg_q.ton_rise;
    assign span = 22'(rise) * 22'(MS_CYC);
    assign tick = ms_q == 15'(MS_CYC - 1);

    always_comb
    begin
        seq_d = seq_q;
        ms_d = tick ? 15'h0000 : ms_q + 15'h0001;
        dly_d = dly_q;
        acc_d = acc_q;
        ref_d = ref_q;
        case (seq_q)
            SEQ_IDLE:
            begin
                ms_d = 15'h0000;
                dly_d = cfg_q.ton_delay;
                if (conv_q)
                begin
                    seq_d = (cfg_q.ton_delay == 7'h00) ? SEQ_RAMP : SEQ_DELAY;
                end
            end
            SEQ_DELAY:
            begin
                if (tick)
                begin
                    dly_d = dly_q - 7'h01;
                    if (dly_q == 7'h01)
                    begin
                        seq_d = SEQ_RAMP;
                        ms_d = 15'h0000;
                    end
                end
            end
            SEQ_RAMP:
            begin
                // Bresenham stepping avoids a divider
                // Limitation: at most one code per cycle, so MS_CYC must be 500 or more
                acc_d = acc_q + 22'(REF_TARGET);
                if (acc_d >= span)
                begin
                    acc_d = acc_d - span;
                    ref_d = ref_q + 10'h001;
                    if (ref_q == REF_TARGET - 10'h001)
                    begin
                        seq_d = SEQ_DONE;
                    end
                end
            end
            SEQ_DONE: ;
            default: seq_d = SEQ_IDLE;
        endcase
        if (!conv_q)
        begin
            seq_d = SEQ_IDLE;
            acc_d = 22'h000000;
            ref_d = 10'h000;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            seq_q <= SEQ_IDLE;
            ms_q <= 15'h0000;
            dly_q <= 7'h00;
            acc_q <= 22'h000000;
            ref_q <= 10'h000;
            ramp_done_q <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            ms_q <= ms_d;
            dly_q <= dly_d;
            acc_q <= acc_d;
            ref_q <= ref_d;
            ramp_done_q <= seq_d == SEQ_DONE;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign avs_o = rsp_q;
    assign cfg_req_o = cfg_req_q;
    assign adc_start_o = adc_start_q;
    assign two_wire_addr_o = tw_addr_q;
    assign two_wire_en_o = tw_en_q;
    assign power_bus_addr_o = pb_addr_q;
    assign power_bus_en_o = pb_en_q;
    assign analog_mode_o = analog_q;
    assign vin_on_level_o = cfg_q.vin_on;
    assign vin_off_level_o = cfg_q.vin_off;
    assign convert_en_o = conv_q;
    assign ls_en_o = ls_en_q;
    assign ls_duty_o = duty_q;
    assign ref_code_o = ref_q;
    assign ramp_done_o = ramp_done_q;
    assign guard_arm_o = guard_q;
    assign fault_o = fault_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    property p_gate_off;
        (!cmp_q.turn_on || !cmp_q.uv_lock_ok || !ready) |=> !conv_q;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("conversion without enable");

    property p_zero_base;
        ((cfg_q.two_wire_base == 7'h00) |=> !tw_en_q) and ((cfg_q.power_bus_base == 7'h00) |=> !pb_en_q);
    endproperty
    a_zero_base: assert property (p_zero_base) else $error("zero base id still enabled");

    property p_analog_quiet;
        analog_q |-> ##1 (!tw_en_q && !pb_en_q);
    endproperty
    a_analog_quiet: assert property (p_analog_quiet) else $error("bus enabled in analog mode");

    property p_analog_lock;
        (analog_q && avs_i.write && take) |=> $stable(cfg_q);
    endproperty
    a_analog_lock: assert property (p_analog_lock) else $error("write in analog mode changed config");

    property p_strap_frozen;
        ready |=> $stable(offset_q) && $stable(analog_q);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed after init");

    property p_ls_first;
        $rose(ls_en_q) |-> duty_q == 4'h1 && $past(hs_seen_q);
    endproperty
    a_ls_first: assert property (p_ls_first) else $error("low side started wrongly");

    property p_duty_step;
        (ls_en_q && $changed(duty_q) && duty_q != 4'h0) |-> duty_q == $past(duty_q) + 4'h1;
    endproperty
    a_duty_step: assert property (p_duty_step) else $error("duty step not one eighth");

    property p_ref_cap;
        ref_q <= REF_TARGET && (seq_q == SEQ_DONE) == (ref_q == REF_TARGET);
    endproperty
    a_ref_cap: assert property (p_ref_cap) else $error("reference beyond target");

    property p_no_ramp_early;
        (seq_q == SEQ_DELAY) |-> ref_q == 10'h000;
    endproperty
    a_no_ramp_early: assert property (p_no_ramp_early) else $error("reference moved during delay");

    property p_guard;
        !$past(reset_i) |-> guard_q;
    endproperty
    a_guard: assert property (p_guard) else $error("guards disarmed");

    property p_one_wait;
        !rsp_q.waitrequest |=> rsp_q.waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("waitrequest low twice");

endmodule

/* File: include/amss_pkg.sv */
// Constants and carrier types for the address-mode and soft-start sequencer.
// Assumes a 25 MHz core clock and a single synchronous reset.
package amss_pkg;

    // ----------------------------------------
    // Bus and register map
    // ----------------------------------------
    localparam int AW = 6;
    localparam logic [AW-1:0] OFS_TWO_WIRE_BASE = 6'h00;
    localparam logic [AW-1:0] OFS_POWER_BUS_BASE = 6'h04;
    localparam logic [AW-1:0] OFS_TON_DELAY = 6'h08;
    localparam logic [AW-1:0] OFS_TON_RISE = 6'h0c;
    localparam logic [AW-1:0] OFS_VIN_ON = 6'h10;
    localparam logic [AW-1:0] OFS_VIN_OFF = 6'h14;
    localparam logic [AW-1:0] OFS_STATUS = 6'h18;
    localparam logic [AW-1:0] OFS_VIN_READ = 6'h1c;
    localparam logic [AW-1:0] OFS_REF_READ = 6'h20;

    // ----------------------------------------
    // Reset values (config store defaults)
    // ----------------------------------------
    localparam logic [6:0] RST_TWO_WIRE_BASE = 7'h10;
    localparam logic [6:0] RST_POWER_BUS_BASE = 7'h40;
    localparam logic [6:0] RST_TON_DELAY = 7'h00;
    localparam logic [6:0] RST_TON_RISE = 7'h02;
    localparam logic [7:0] RST_VIN_ON = 8'h0a;
    localparam logic [7:0] RST_VIN_OFF = 8'h0a;

    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int ST_LOADED = 0;
    localparam int ST_ANALOG = 1;
    localparam int ST_CONVERT = 2;
    localparam int ST_RAMP_DONE = 3;
    localparam int ST_FAULT = 4;
    localparam int ST_VIN_OV = 5;
    localparam int ST_VIN_UVW = 6;
    localparam int ST_OFFSET_LSB = 8;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [4:0] LS_STEP_CYCLES = 5'h10;
    localparam logic [3:0] LS_FULL_STEPS = 4'h8;
    localparam logic [9:0] REF_TARGET = 10'h1f4;

    // ----------------------------------------
    // Strap decode bounds, midway between nominal codes
    // ----------------------------------------
    localparam logic [14:0][9:0] STRAP_BOUND = {10'h2bf, 10'h27f, 10'h246, 10'h20b, 10'h1d0,
        10'h197, 10'h160, 10'h131, 10'h105, 10'h0dd, 10'h0b7, 10'h091, 10'h070, 10'h051, 10'h030};
    localparam logic [9:0] STRAP_FLOAT = 10'h370;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [AW-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } amss_avreq_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } amss_avrsp_t;

    typedef struct packed {
        logic [6:0] two_wire_base;
        logic [6:0] power_bus_base;
        logic [6:0] ton_delay;
        logic [6:0] ton_rise;
        logic [7:0] vin_on;
        logic [7:0] vin_off;
    } amss_cfg_t;

    localparam amss_cfg_t RST_CFG = '{RST_TWO_WIRE_BASE, RST_POWER_BUS_BASE, RST_TON_DELAY,
        RST_TON_RISE, RST_VIN_ON, RST_VIN_OFF};

    typedef struct packed {
        logic turn_on;
        logic uv_lock_ok;
        logic vin_ov;
        logic vin_uvw;
        logic oc_trip;
        logic ov_trip;
    } amss_cmp_t;

    typedef enum logic [1:0] {INIT_LOAD, INIT_STRAP, INIT_READY} amss_init_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_RAMP, SEQ_DONE} amss_seq_t;

endpackage

/* File: dv/amss_partner.sv */
// Far side model: config store, strap converter and PWM tick.
// Assumes the core's clock; runs without reset.
`timescale 1ns/1ps
module amss_partner
    import amss_pkg::*;
(
    // Core side
    input wire logic clock_i,
    input wire logic cfg_req_i,
    input wire logic adc_start_i,
    input wire logic [9:0] strap_i,
    // Answers
    output logic cfg_ack_o,
    output amss_cfg_t cfg_data_o,
    output logic adc_done_o,
    output logic [9:0] adc_code_o,
    output logic pwm_cycle_o
);
    logic [3:0] cnt_q = 4'h0;

    // Data only valid in the cycle after its request; inverted otherwise
    always @(posedge clock_i)
    begin
        cnt_q <= cnt_q + 4'h1;
        pwm_cycle_o <= cnt_q == 4'h0;
        cfg_ack_o <= cfg_req_i && !cfg_ack_o && cnt_q[1];
        cfg_data_o <= cfg_req_i ? RST_CFG : ~RST_CFG;
        adc_done_o <= adc_start_i;
        adc_code_o <= adc_start_i ? strap_i : ~strap_i;
    end
endmodule

/* File: dv/amss_core_test.sv */
// Self-checking bench for the start-up sequencer core.
// Assumes amss_partner for store, strap converter and PWM.
`timescale 1ns/1ps
module amss_core_test
    import amss_pkg::*;
;
    logic clock_i;
    logic reset_i;
    amss_avreq_t avs_i;
    amss_avrsp_t avs_o;
    amss_cfg_t cfg_data;
    amss_cmp_t cmp;
    logic cfg_req, cfg_ack, adc_start, adc_done, pwm, hs_gate;
    logic tw_en, pb_en, analog, conv, ls_en, done, arm, fault;
    logic [9:0] strap, adc_code, ref_code;
    logic [6:0] tw_addr, pb_addr;
    logic [7:0] von, voff;
    logic [3:0] duty;
    logic [31:0] q;
    logic [9:0] codes [3] = '{10'h000, 10'h2c0, 10'h060};
    logic [6:0] offs [3] = '{7'h0, 7'hf, 7'h2};
    int n_mismatch = 0;
    int compares = 0;
    int n;

    amss_core #(.MS_CYC(500)) amss_core_inst (.clock_i(clock_i), .reset_i(reset_i), .avs_i(avs_i),
        .avs_o(avs_o), .cfg_req_o(cfg_req), .cfg_ack_i(cfg_ack), .cfg_data_i(cfg_data),
        .adc_start_o(adc_start), .adc_done_i(adc_done), .adc_code_i(adc_code), .vin_code_i(10'h155),
        .cmp_i(cmp), .pwm_cycle_i(pwm), .hs_gate_i(hs_gate), .two_wire_addr_o(tw_addr),
        .two_wire_en_o(tw_en), .power_bus_addr_o(pb_addr), .power_bus_en_o(pb_en),
        .analog_mode_o(analog), .vin_on_level_o(von), .vin_off_level_o(voff), .convert_en_o(conv),
        .ls_en_o(ls_en), .ls_duty_o(duty), .ref_code_o(ref_code), .ramp_done_o(done),
        .guard_arm_o(arm), .fault_o(fault));
    amss_partner amss_partner_inst (.clock_i(clock_i), .cfg_req_i(cfg_req), .adc_start_i(adc_start),
        .strap_i(strap), .cfg_ack_o(cfg_ack), .cfg_data_o(cfg_data), .adc_done_o(adc_done),
        .adc_code_o(adc_code), .pwm_cycle_o(pwm));

    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock_i);
        avs_i <= '{!wr, wr, a, d, 4'hf};
        do
        begin
            @(posedge clock_i);
            k++;
        end
        while (avs_o.waitrequest !== 1'b0);
        chk(k, 32'd2);
        q = avs_o.readdata;
        avs_i <= '{1'b0, 1'b0, a, d, 4'hf};
    endtask

    // Waits for ramp_done when sel is set, for conversion otherwise
    task automatic upto(input logic sel, input int lim);
        n = 0;
        while ((sel ? done : conv) !== 1'b1 && n < lim)
        begin
            @(posedge clock_i);
            n++;
        end
    endtask

    task automatic rst(input logic [9:0] code);
        strap <= code;
        reset_i <= 1'b1;
        tick(12);
        reset_i <= 1'b0;
        tick(30);
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        tick(10000);
        n_mismatch++;
        results;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        reset_i = 1'b1;
        strap = 10'h3ff;
        avs_i = '0;
        cmp = '0;
        hs_gate = 1'b0;
        rst(10'h3ff);
        chk({analog, tw_en, pb_en}, 3'b100);
        bus(1'b1, OFS_TON_RISE, 32'h5);
        bus(1'b0, OFS_TON_RISE, 32'h0);
        chk(q, 32'h2);
        for (int i = 0; i < 3; i++)
        begin
            rst(codes[i]);
            chk(tw_addr, 7'h10 + offs[i]);
            chk(pb_addr, 7'h40 + offs[i]);
        end
        chk({analog, tw_en, pb_en}, 3'b011);
        strap <= 10'h3ff;
        tick(20);
        chk(tw_addr, 7'h12);
        bus(1'b1, OFS_TWO_WIRE_BASE, 32'h0);
        tick(3);
        chk({tw_en, pb_en}, 2'b01);
        bus(1'b1, OFS_TWO_WIRE_BASE, 32'h20);
        tick(3);
        chk(tw_addr, 7'h22);
        bus(1'b0, OFS_VIN_ON, 32'h0);
        chk(q, 32'h0a);
        bus(1'b1, OFS_VIN_ON, 32'h0c);
        tick(2);
        chk(von, 8'h0c);
        chk(voff, 8'h0a);
        bus(1'b0, OFS_VIN_READ, 32'h0);
        chk(q, 32'h155);
        bus(1'b0, 6'h3c, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_TON_DELAY, 32'h1);
        bus(1'b1, OFS_TON_RISE, 32'h2);
        cmp <= 6'b100000;
        tick(10);
        chk(conv, 1'b0);
        cmp <= 6'b110000;
        upto(1'b0, 10);
        chk(conv, 1'b1);
        tick(20);
        chk({ls_en, ref_code}, 11'h0);
        hs_gate <= 1'b1;
        tick(1);
        hs_gate <= 1'b0;
        tick(4);
        chk({ls_en, duty}, 5'h11);
        tick(380);
        chk(duty, 4'h2);
        // Done 1 ms delay plus 2 ms rise after conversion, 405 cycles already gone
        upto(1'b1, 1200);
        chk(n >= 1090 && n <= 1100, 1'b1);
        chk(ref_code, 10'h1f4);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h0000_020d);
        bus(1'b0, OFS_REF_READ, 32'h0);
        chk(q, 32'h1f4);
        tick(600);
        chk(duty, 4'h8);
        chk(arm, 1'b1);
        cmp <= 6'b110010;
        tick(8);
        chk({fault, conv}, 2'b10);
        results;
    end
endmodule
